//--- swo_pkg.sv
/*
  Constants, field layouts and enumerations for the switch output controller.
  Assumes a 100 MHz device clock and a word-aligned plain register port.
*/
package swo_pkg;
  // Timing
  localparam int CLK_PERIOD_NS     = 10;
  localparam int DELAY_STEP_NS     = 100_000_000;
  localparam int DELAY_STEP_CYCLES = (DELAY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DELAY_W           = 10;
  localparam logic [DELAY_W-1:0] DELAY_MAX = 10'h3E8;

  // Measured variables and data width
  localparam int NUM_VARS = 12;
  localparam int VAL_W    = 32;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_ON_VAL  = 8'h04;
  localparam logic [7:0] ADDR_OFF_VAL = 8'h08;
  localparam logic [7:0] ADDR_ON_DLY  = 8'h0C;
  localparam logic [7:0] ADDR_OFF_DLY = 8'h10;
  localparam logic [7:0] ADDR_STATUS  = 8'h14;

  // Control register fields
  localparam int CTRL_W         = 15;
  localparam int CTRL_FUNC_LSB  = 0;
  localparam int CTRL_DIAG_LSB  = 3;
  localparam int CTRL_FAIL_LSB  = 5;
  localparam int CTRL_INV_BIT   = 7;
  localparam int CTRL_SRC_LSB   = 8;
  localparam int CTRL_LIM_LSB   = 11;
  localparam int LIM_SEL_W      = 4;

  // Status register fields
  localparam int ST_PIN      = 0;
  localparam int ST_LIMIT    = 1;
  localparam int ST_ON_PEND  = 2;
  localparam int ST_OFF_PEND = 3;

  // Reset values
  localparam logic [CTRL_W-1:0]  CTRL_RST = 15'h0000;
  localparam logic [VAL_W-1:0]   VAL_RST  = 32'h0000_0000;
  localparam logic [DELAY_W-1:0] DLY_RST  = 10'h000;

  typedef enum logic [2:0] {
    SWO_FN_OFF     = 3'h0,
    SWO_FN_ON      = 3'h1,
    SWO_FN_DIAG    = 3'h2,
    SWO_FN_LIMIT   = 3'h3,
    SWO_FN_DIGITAL = 3'h4
  } swo_func_e;

  typedef enum logic [1:0] {
    SWO_DG_ALARM      = 2'h0,
    SWO_DG_ALARM_WARN = 2'h1,
    SWO_DG_WARN       = 2'h2
  } swo_diag_e;

  typedef enum logic [1:0] {
    SWO_FM_ACTUAL = 2'h0,
    SWO_FM_OPEN   = 2'h1,
    SWO_FM_CLOSED = 2'h2
  } swo_fail_e;

  typedef enum logic [2:0] {
    SWO_SRC_OFF = 3'h0,
    SWO_SRC_AD1 = 3'h1,
    SWO_SRC_AD2 = 3'h2,
    SWO_SRC_DO1 = 3'h3,
    SWO_SRC_DO2 = 3'h4,
    SWO_SRC_DO3 = 3'h5,
    SWO_SRC_DO4 = 3'h6
  } swo_src_e;
endpackage : swo_pkg

//--- swo_tmr_if.sv
/*
  Interface between the controller and one delay timer.
  Assumes both ends share ref_clk; tick is a one-cycle step enable.
*/
`timescale 1ns/1ps
interface swo_tmr_if;
  logic                        req;
  logic [swo_pkg::DELAY_W-1:0] delay;
  logic                        tick;
  logic                        done;
  logic                        pending;

  modport owner (output req, output delay, output tick, input done, input pending);
  modport timer (input req, input delay, input tick, output done, output pending);
endinterface : swo_tmr_if

//--- swo_delay_timer.sv
/*
  Delay timer counting tenth-second steps while its request is held.
  Assumes the owner drives req, delay and tick from ref_clk logic.
*/
`timescale 1ns/1ps
module swo_delay_timer (
  input wire logic ref_clk,
  input wire logic reset_n,
  swo_tmr_if.timer tmr
);
  logic [swo_pkg::DELAY_W-1:0] cnt_ff;
  logic [swo_pkg::DELAY_W-1:0] nxt_cnt;

  always_comb begin
    if (!tmr.req) begin
      nxt_cnt = '0;
    end else if (tmr.tick && (cnt_ff < tmr.delay)) begin
      nxt_cnt = cnt_ff + 10'h001;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Zero delay completes at once; a dropped request never completes
  assign tmr.done    = tmr.req && (cnt_ff >= tmr.delay);
  assign tmr.pending = tmr.req && !tmr.done;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_restart_idle: assert property (!tmr.req |=> cnt_ff == '0)
    else $error("timer count not cleared after request dropped");
  a_hold_no_tick: assert property ((tmr.req && !tmr.tick) ##1 tmr.req |-> $stable(cnt_ff))
    else $error("timer advanced without a step tick");
endmodule : swo_delay_timer

//--- swo_switch_output.sv
/*
  Switch output controller: function select, limit comparator with hysteresis
  and on/off delays, failure-mode override, inversion and status readback.
  Assumes measured values, event flags and discrete sources come from logic
  on ref_clk, and a register master that never waits.
*/
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module swo_switch_output #(
  parameter int TICK_CYCLES = swo_pkg::DELAY_STEP_CYCLES,
  parameter int NUM_VARS    = swo_pkg::NUM_VARS
) (
  input  wire logic                           ref_clk,
  input  wire logic                           reset_n,
  input  wire logic [7:0]                     reg_addr,
  input  wire logic [31:0]                    reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [31:0]                    reg_rdata,
  input  wire logic [NUM_VARS*swo_pkg::VAL_W-1:0] meas_values,
  input  wire logic                           alarm_active,
  input  wire logic                           warning_active,
  input  wire logic [1:0]                     adv_diag_sw,
  input  wire logic [3:0]                     discrete_out,
  output logic                                switch_closed
);
  localparam int VW = swo_pkg::VAL_W;

  logic [swo_pkg::CTRL_W-1:0]    ctrl_ff;
  logic signed [VW-1:0]          on_val_ff;
  logic signed [VW-1:0]          off_val_ff;
  logic [swo_pkg::DELAY_W-1:0]   on_dly_ff;
  logic [swo_pkg::DELAY_W-1:0]   off_dly_ff;
  logic [31:0]                   rdata_ff;
  logic [31:0]                   tick_cnt_ff;
  logic                          tick_ff;
  logic                          lim_ff;
  logic                          pin_ff;
  logic                          nxt_pin;
  logic                          base_state;
  logic                          diag_evt;
  logic                          src_val;
  logic                          lim_active;
  logic                          on_cond;
  logic                          off_cond;
  logic                          on_above;
  logic signed [VW-1:0]          meas_sel;
  logic [swo_pkg::LIM_SEL_W-1:0] lim_sel;
  logic                          inv;
  swo_pkg::swo_func_e            func;
  swo_pkg::swo_diag_e            diag_sel;
  swo_pkg::swo_fail_e            fail_sel;
  swo_pkg::swo_src_e             src_sel;

  swo_tmr_if on_tmr ();
  swo_tmr_if off_tmr ();

  // Above/below comparison against one threshold
  function automatic logic beyond(input logic signed [VW-1:0] v,
                                  input logic signed [VW-1:0] thr,
                                  input logic                 above);
    beyond = above ? (v > thr) : (v < thr);
  endfunction : beyond

  // Out-of-range delays are clamped so the timer always completes
  function automatic logic [swo_pkg::DELAY_W-1:0] clamp_dly(input logic [31:0] w);
    if (w > {22'h000000, swo_pkg::DELAY_MAX}) begin
      clamp_dly = swo_pkg::DELAY_MAX;
    end else begin
      clamp_dly = w[swo_pkg::DELAY_W-1:0];
    end
  endfunction : clamp_dly

  ////////////////////////////////////////////////////////////////////////////
  // Field decode
  assign func     = swo_pkg::swo_func_e'(ctrl_ff[swo_pkg::CTRL_FUNC_LSB +: 3]);
  assign diag_sel = swo_pkg::swo_diag_e'(ctrl_ff[swo_pkg::CTRL_DIAG_LSB +: 2]);
  assign fail_sel = swo_pkg::swo_fail_e'(ctrl_ff[swo_pkg::CTRL_FAIL_LSB +: 2]);
  assign src_sel  = swo_pkg::swo_src_e'(ctrl_ff[swo_pkg::CTRL_SRC_LSB +: 3]);
  assign lim_sel  = ctrl_ff[swo_pkg::CTRL_LIM_LSB +: swo_pkg::LIM_SEL_W];
  assign inv      = ctrl_ff[swo_pkg::CTRL_INV_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff    <= swo_pkg::CTRL_RST;
      on_val_ff  <= swo_pkg::VAL_RST;
      off_val_ff <= swo_pkg::VAL_RST;
      on_dly_ff  <= swo_pkg::DLY_RST;
      off_dly_ff <= swo_pkg::DLY_RST;
    end else if (reg_wr) begin
      if (reg_addr == swo_pkg::ADDR_CTRL) begin
        ctrl_ff <= reg_wdata[swo_pkg::CTRL_W-1:0];
      end else if (reg_addr == swo_pkg::ADDR_ON_VAL) begin
        on_val_ff <= reg_wdata;
      end else if (reg_addr == swo_pkg::ADDR_OFF_VAL) begin
        off_val_ff <= reg_wdata;
      end else if (reg_addr == swo_pkg::ADDR_ON_DLY) begin
        on_dly_ff <= clamp_dly(reg_wdata);
      end else if (reg_addr == swo_pkg::ADDR_OFF_DLY) begin
        off_dly_ff <= clamp_dly(reg_wdata);
      end
    end
  end

  // Register reads: data only in the cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (reg_addr == swo_pkg::ADDR_CTRL) begin
        rdata_ff <= {17'h00000, ctrl_ff};
      end else if (reg_addr == swo_pkg::ADDR_ON_VAL) begin
        rdata_ff <= on_val_ff;
      end else if (reg_addr == swo_pkg::ADDR_OFF_VAL) begin
        rdata_ff <= off_val_ff;
      end else if (reg_addr == swo_pkg::ADDR_ON_DLY) begin
        rdata_ff <= {22'h000000, on_dly_ff};
      end else if (reg_addr == swo_pkg::ADDR_OFF_DLY) begin
        rdata_ff <= {22'h000000, off_dly_ff};
      end else if (reg_addr == swo_pkg::ADDR_STATUS) begin
        rdata_ff <= {28'h0000000, off_tmr.pending, on_tmr.pending, lim_ff, pin_ff};
      end else begin
        rdata_ff <= 32'h0000_0000;
      end
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Tenth-second step divider, free running; shared by both timers, so a
  // delay may finish up to one step early depending on phase
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_ff <= 32'h0000_0000;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_ff <= 32'h0000_0000;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
      tick_ff     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Limit comparator with hysteresis
  always_comb begin
    meas_sel = '0;
    for (int i = 0; i < NUM_VARS; i++) begin
      if (32'(lim_sel) == 32'(i + 1)) begin
        meas_sel = meas_values[i*VW +: VW];
      end
    end
  end

  // Equal thresholds are handled as the on-above-off case
  assign on_above   = (on_val_ff >= off_val_ff);
  assign lim_active = (func == swo_pkg::SWO_FN_LIMIT) && (lim_sel != '0);
  assign on_cond    = beyond(meas_sel, on_val_ff, on_above);
  assign off_cond   = beyond(meas_sel, off_val_ff, !on_above);

  assign on_tmr.req    = lim_active && !lim_ff && on_cond;
  assign on_tmr.delay  = on_dly_ff;
  assign on_tmr.tick   = tick_ff;
  assign off_tmr.req   = lim_active && lim_ff && off_cond;
  assign off_tmr.delay = off_dly_ff;
  assign off_tmr.tick  = tick_ff;

  swo_delay_timer u_on_tmr (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .tmr     (on_tmr)
  );

  swo_delay_timer u_off_tmr (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .tmr     (off_tmr)
  );

  // Limit state: closed at reset and outside limit mode; otherwise moves only when a delay completes
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lim_ff <= 1'b1;
    end else if (!lim_active) begin
      lim_ff <= 1'b1;
    end else if (on_tmr.done) begin
      lim_ff <= 1'b1;
    end else if (off_tmr.done) begin
      lim_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output selection
  always_comb begin
    case (diag_sel)
      swo_pkg::SWO_DG_ALARM:      diag_evt = alarm_active;
      swo_pkg::SWO_DG_ALARM_WARN: diag_evt = alarm_active || warning_active;
      swo_pkg::SWO_DG_WARN:       diag_evt = warning_active;
      default:                    diag_evt = 1'b0;
    endcase
  end

  always_comb begin
    case (src_sel)
      swo_pkg::SWO_SRC_AD1: src_val = adv_diag_sw[0];
      swo_pkg::SWO_SRC_AD2: src_val = adv_diag_sw[1];
      swo_pkg::SWO_SRC_DO1: src_val = discrete_out[0];
      swo_pkg::SWO_SRC_DO2: src_val = discrete_out[1];
      swo_pkg::SWO_SRC_DO3: src_val = discrete_out[2];
      swo_pkg::SWO_SRC_DO4: src_val = discrete_out[3];
      default:              src_val = 1'b0;
    endcase
  end

  always_comb begin
    case (func)
      swo_pkg::SWO_FN_OFF:     base_state = 1'b0;
      swo_pkg::SWO_FN_ON:      base_state = 1'b1;
      swo_pkg::SWO_FN_DIAG:    base_state = !diag_evt;
      swo_pkg::SWO_FN_LIMIT:   base_state = lim_ff;
      swo_pkg::SWO_FN_DIGITAL: base_state = src_val;
      default:                 base_state = 1'b0;
    endcase
    if (((func == swo_pkg::SWO_FN_LIMIT) || (func == swo_pkg::SWO_FN_DIGITAL)) && alarm_active) begin
      if (fail_sel == swo_pkg::SWO_FM_OPEN) begin
        base_state = 1'b0;
      end else if (fail_sel == swo_pkg::SWO_FM_CLOSED) begin
        base_state = 1'b1;
      end
    end
    nxt_pin = base_state ^ inv;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_ff <= 1'b0;
    end else begin
      pin_ff <= nxt_pin;
    end
  end

  assign switch_closed = pin_ff;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_on_wait;
    on_tmr.req && !on_tmr.done;
  endsequence

  sequence s_on_fire;
    on_tmr.done;
  endsequence

  a_off_open: assert property (func == swo_pkg::SWO_FN_OFF |=> switch_closed == $past(inv))
    else $error("off function did not open the output");
  a_on_closed: assert property (func == swo_pkg::SWO_FN_ON |=> switch_closed != $past(inv))
    else $error("on function did not close the output");
  a_diag_event: assert property ((func == swo_pkg::SWO_FN_DIAG) && diag_evt
                                 |=> switch_closed == $past(inv))
    else $error("diagnostic event did not open the output");
  a_diag_warn_only: assert property ((func == swo_pkg::SWO_FN_DIAG) && alarm_active &&
                                     !warning_active && (diag_sel == swo_pkg::SWO_DG_WARN)
                                     |=> switch_closed != $past(inv))
    else $error("warning-only selection reacted to an alarm");
  a_digital_follow: assert property ((func == swo_pkg::SWO_FN_DIGITAL) && !alarm_active &&
                                     (src_sel == swo_pkg::SWO_SRC_DO3)
                                     |=> switch_closed == ($past(discrete_out[2]) ^ $past(inv)))
    else $error("digital mode did not follow the selected source");
  a_on_delay_gate: assert property (s_on_wait |=> !lim_ff)
    else $error("limit state closed before the on delay elapsed");
  // An alarm or a mode change right after completion legitimately overrides the pin
  a_on_fire_close: assert property (s_on_fire ##1 ((func == swo_pkg::SWO_FN_LIMIT) && !alarm_active)
                                    |-> lim_ff ##1 (switch_closed != $past(inv)))
    else $error("completed on delay did not close the output");
  a_limit_hold: assert property (lim_active && !on_tmr.done && !off_tmr.done |=> $stable(lim_ff))
    else $error("limit state changed without a completed delay");
  a_fail_closed: assert property (((func == swo_pkg::SWO_FN_LIMIT) ||
                                   (func == swo_pkg::SWO_FN_DIGITAL)) && alarm_active &&
                                  (fail_sel == swo_pkg::SWO_FM_CLOSED)
                                  |=> switch_closed != $past(inv))
    else $error("failure mode closed was not applied");
  a_status_pin: assert property (reg_rd && (reg_addr == swo_pkg::ADDR_STATUS)
                                 |=> reg_rdata[swo_pkg::ST_PIN] == $past(switch_closed))
    else $error("status did not report the output pin");
endmodule : swo_switch_output

//--- swo_load_model.sv
/*
  Model of the external circuit wired to the switch output: a load that draws
  current while the switch conducts, and a counter of switching transitions.
  Assumes switch_closed is driven from ref_clk logic; 1 means conductive.
*/
`timescale 1ns/1ps
module swo_load_model (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       switch_closed,
  output logic            load_on,
  output logic      [7:0] toggles
);
  logic last_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Load current follows the contact directly; a real load has no memory
  assign load_on = switch_closed;

  // Transitions counted so forced Off/On steps can be seen at the circuit
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      last_ff <= 1'b0;
      toggles <= 8'h00;
    end else begin
      last_ff <= switch_closed;
      if (last_ff != switch_closed) begin
        toggles <= toggles + 8'h01;
      end
    end
  end
endmodule : swo_load_model

//--- swo_switch_output_test.sv
/*
  Self-checking bench for the switch output controller: reset readback, table of
  mode cases, then register, limit, delay, load and mid-run reset tests.
  Assumes the delay step is shortened to 4 cycles; variable 2 feeds the limit.
*/
`timescale 1ns/1ps
`define CHK(act, exp) begin checks_done++; if ((act) !== (exp)) begin miscompares++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (act), (exp)); end end
module swo_switch_output_test;
  typedef struct {
    logic [14:0] ctrl;
    logic        al;
    logic        wn;
    logic [1:0]  ad;
    logic [3:0]  dc;
    logic        ex;
  } swo_row_s;

  logic                                           ref_clk;
  logic                                           reset_n;
  logic [7:0]                                     reg_addr;
  logic [31:0]                                    reg_wdata;
  logic                                           reg_wr;
  logic                                           reg_rd;
  logic [31:0]                                    reg_rdata;
  logic [swo_pkg::NUM_VARS*swo_pkg::VAL_W-1:0]    meas_values;
  logic                                           alarm_active;
  logic                                           warning_active;
  logic [1:0]                                     adv_diag_sw;
  logic [3:0]                                     discrete_out;
  logic                                           switch_closed;
  logic                                           load_on;
  logic [7:0]                                     toggles;
  logic [31:0]                                    rd;
  logic [7:0]                                     t0;
  int                                             miscompares;
  int                                             checks_done;
  int                                             n;
  swo_row_s                                       rows[$];

  swo_switch_output #(.TICK_CYCLES(4)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_values(meas_values),
    .alarm_active(alarm_active), .warning_active(warning_active),
    .adv_diag_sw(adv_diag_sw), .discrete_out(discrete_out), .switch_closed(switch_closed)
  );

  swo_load_model load (
    .ref_clk(ref_clk), .reset_n(reset_n), .switch_closed(switch_closed),
    .load_on(load_on), .toggles(toggles)
  );

  ////////////////////////////////////////////////////////////////////////////
  always #5 ref_clk = ~ref_clk;

  task results();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  task reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe edge
  task reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  task settle(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask : settle

  task set_meas(input logic [31:0] v);
    @(posedge ref_clk);
    meas_values[63:32] <= v;
  endtask : set_meas

  // Bounded so a stuck pin ends as a mismatch, not a hang
  task wait_pin(input logic v, output int c);
    c = 0;
    while (switch_closed !== v && c < 60) begin
      @(posedge ref_clk);
      #1;
      c++;
    end
  endtask : wait_pin

  // ctrl = {limit var, source, invert, failure mode, diag class, function}
  function automatic swo_row_s row(logic [2:0] fn, logic [1:0] dg, logic [1:0] fm,
                                   logic inv, logic [2:0] src, logic al, logic wn,
                                   logic [1:0] ad, logic [3:0] dc, logic ex);
    row.ctrl = {4'h0, src, inv, fm, dg, fn};
    row.al = al;
    row.wn = wn;
    row.ad = ad;
    row.dc = dc;
    row.ex = ex;
  endfunction : row

  initial begin
    #300_000;
    miscompares++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0; reset_n = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
    reg_wr = 1'b0; reg_rd = 1'b0; meas_values = '0; alarm_active = 1'b0;
    warning_active = 1'b0; adv_diag_sw = 2'h0; discrete_out = 4'h0;
    miscompares = 0; checks_done = 0;
    rows.push_back(row(3'h0, 2'h0, 2'h2, 1'b0, 3'h0, 1'b1, 1'b1, 2'h3, 4'hF, 1'b0));
    rows.push_back(row(3'h0, 2'h0, 2'h0, 1'b1, 3'h0, 1'b0, 1'b0, 2'h0, 4'h0, 1'b1));
    rows.push_back(row(3'h1, 2'h0, 2'h1, 1'b0, 3'h0, 1'b1, 1'b1, 2'h0, 4'h0, 1'b1));
    rows.push_back(row(3'h1, 2'h0, 2'h0, 1'b1, 3'h0, 1'b0, 1'b0, 2'h0, 4'h0, 1'b0));
    rows.push_back(row(3'h2, 2'h0, 2'h0, 1'b0, 3'h0, 1'b0, 1'b0, 2'h0, 4'h0, 1'b1));
    rows.push_back(row(3'h2, 2'h0, 2'h2, 1'b0, 3'h0, 1'b1, 1'b0, 2'h0, 4'h0, 1'b0));
    rows.push_back(row(3'h2, 2'h0, 2'h0, 1'b0, 3'h0, 1'b0, 1'b1, 2'h0, 4'h0, 1'b1));
    rows.push_back(row(3'h2, 2'h1, 2'h0, 1'b0, 3'h0, 1'b0, 1'b1, 2'h0, 4'h0, 1'b0));
    rows.push_back(row(3'h2, 2'h1, 2'h0, 1'b0, 3'h0, 1'b1, 1'b0, 2'h0, 4'h0, 1'b0));
    rows.push_back(row(3'h2, 2'h2, 2'h0, 1'b0, 3'h0, 1'b1, 1'b0, 2'h0, 4'h0, 1'b1));
    rows.push_back(row(3'h2, 2'h2, 2'h0, 1'b0, 3'h0, 1'b0, 1'b1, 2'h0, 4'h0, 1'b0));
    rows.push_back(row(3'h2, 2'h2, 2'h0, 1'b1, 3'h0, 1'b0, 1'b1, 2'h0, 4'h0, 1'b1));
    rows.push_back(row(3'h4, 2'h0, 2'h0, 1'b0, 3'h0, 1'b0, 1'b0, 2'h3, 4'hF, 1'b0));
    rows.push_back(row(3'h4, 2'h0, 2'h0, 1'b0, 3'h1, 1'b0, 1'b0, 2'h1, 4'h0, 1'b1));
    rows.push_back(row(3'h4, 2'h0, 2'h0, 1'b0, 3'h1, 1'b0, 1'b0, 2'h2, 4'hF, 1'b0));
    rows.push_back(row(3'h4, 2'h0, 2'h0, 1'b0, 3'h2, 1'b0, 1'b0, 2'h2, 4'h0, 1'b1));
    rows.push_back(row(3'h4, 2'h0, 2'h0, 1'b0, 3'h3, 1'b0, 1'b0, 2'h0, 4'h1, 1'b1));
    rows.push_back(row(3'h4, 2'h0, 2'h0, 1'b0, 3'h4, 1'b0, 1'b0, 2'h3, 4'h1, 1'b0));
    rows.push_back(row(3'h4, 2'h0, 2'h0, 1'b0, 3'h4, 1'b0, 1'b0, 2'h0, 4'h2, 1'b1));
    rows.push_back(row(3'h4, 2'h0, 2'h0, 1'b0, 3'h5, 1'b0, 1'b0, 2'h0, 4'h4, 1'b1));
    rows.push_back(row(3'h4, 2'h0, 2'h0, 1'b0, 3'h6, 1'b0, 1'b0, 2'h0, 4'h8, 1'b1));
    rows.push_back(row(3'h4, 2'h0, 2'h0, 1'b0, 3'h6, 1'b0, 1'b0, 2'h0, 4'h7, 1'b0));
    rows.push_back(row(3'h4, 2'h0, 2'h0, 1'b0, 3'h3, 1'b1, 1'b0, 2'h0, 4'h1, 1'b1));
    rows.push_back(row(3'h4, 2'h0, 2'h1, 1'b0, 3'h3, 1'b1, 1'b0, 2'h0, 4'h1, 1'b0));
    rows.push_back(row(3'h4, 2'h0, 2'h2, 1'b0, 3'h3, 1'b1, 1'b0, 2'h0, 4'h0, 1'b1));
    rows.push_back(row(3'h4, 2'h0, 2'h1, 1'b1, 3'h3, 1'b1, 1'b0, 2'h0, 4'h1, 1'b1));
    rows.push_back(row(3'h4, 2'h0, 2'h1, 1'b0, 3'h3, 1'b0, 1'b0, 2'h0, 4'h1, 1'b1));
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    settle(1);
    `CHK(switch_closed, 1'b0)
    // Limit state resets to closed, so status shows that bit alone
    for (int a = 0; a <= 20; a += 4) begin
      reg_read(8'(a), rd);
      `CHK(rd, (8'(a) == swo_pkg::ADDR_STATUS) ? (32'h1 << swo_pkg::ST_LIMIT) : 32'h0)
    end
    foreach (rows[i]) begin
      @(posedge ref_clk);
      alarm_active   <= rows[i].al;
      warning_active <= rows[i].wn;
      adv_diag_sw    <= rows[i].ad;
      discrete_out   <= rows[i].dc;
      reg_write(swo_pkg::ADDR_CTRL, {17'h0, rows[i].ctrl});
      settle(3);
      `CHK(switch_closed, rows[i].ex)
      `CHK(load_on, rows[i].ex)
      reg_read(swo_pkg::ADDR_STATUS, rd);
      `CHK(rd[swo_pkg::ST_PIN], rows[i].ex)
    end
    alarm_active <= 1'b0;
    reg_write(swo_pkg::ADDR_ON_DLY, 32'h0000_07FF);
    reg_read(swo_pkg::ADDR_ON_DLY, rd);
    `CHK(rd, 32'h0000_03E8)
    reg_write(8'h18, 32'hFFFF_FFFF);
    reg_read(8'h18, rd);
    `CHK(rd, 32'h0)
    // Limit mode on variable 2, on 100 above off -50, no delays
    reg_write(swo_pkg::ADDR_ON_VAL, 32'd100);
    reg_write(swo_pkg::ADDR_OFF_VAL, 32'hFFFF_FFCE);
    reg_read(swo_pkg::ADDR_ON_VAL, rd);
    `CHK(rd, 32'd100)
    reg_write(swo_pkg::ADDR_ON_DLY, 32'h0);
    reg_write(swo_pkg::ADDR_OFF_DLY, 32'h0);
    reg_write(swo_pkg::ADDR_CTRL, 32'h0000_1003);
    settle(3);
    `CHK(switch_closed, 1'b1)
    set_meas(32'hFFFF_FFC4); settle(4);
    `CHK(switch_closed, 1'b0)
    set_meas(32'h0); settle(4);
    `CHK(switch_closed, 1'b0)
    set_meas(32'd150); settle(4);
    `CHK(switch_closed, 1'b1)
    reg_write(swo_pkg::ADDR_ON_VAL, 32'hFFFF_FFCE);
    reg_write(swo_pkg::ADDR_OFF_VAL, 32'd100);
    settle(4);
    `CHK(switch_closed, 1'b0)
    set_meas(32'h0); settle(4);
    `CHK(switch_closed, 1'b0)
    set_meas(32'hFFFF_FFC4); settle(4);
    `CHK(switch_closed, 1'b1)
    @(posedge ref_clk);
    alarm_active <= 1'b1;
    reg_write(swo_pkg::ADDR_CTRL, 32'h0000_1023);
    settle(3);
    `CHK(switch_closed, 1'b0)
    reg_write(swo_pkg::ADDR_CTRL, 32'h0000_1003);
    alarm_active <= 1'b0;
    reg_write(swo_pkg::ADDR_ON_DLY, 32'd5);
    reg_write(swo_pkg::ADDR_OFF_DLY, 32'd3);
    settle(3);
    set_meas(32'd150);
    wait_pin(1'b0, n);
    `CHK(n inside {[6:15]}, 1'b1)
    set_meas(32'hFFFF_FFC4); settle(8);
    `CHK(switch_closed, 1'b0)
    reg_read(swo_pkg::ADDR_STATUS, rd);
    `CHK(rd[swo_pkg::ST_ON_PEND], 1'b1)
    set_meas(32'h0); settle(30);
    `CHK(switch_closed, 1'b0)
    set_meas(32'hFFFF_FFC4);
    wait_pin(1'b1, n);
    `CHK(n inside {[14:24]}, 1'b1)
    // Operator steps the attached circuit through forced states
    reg_write(swo_pkg::ADDR_CTRL, 32'h0);
    settle(3);
    t0 = toggles;
    reg_write(swo_pkg::ADDR_CTRL, 32'h1);
    settle(3);
    reg_write(swo_pkg::ADDR_CTRL, 32'h0);
    settle(3);
    `CHK(toggles, 8'(t0 + 8'h02))
    // Reset in mid-run returns the block to Off with the output open
    reg_write(swo_pkg::ADDR_CTRL, 32'h1);
    settle(3);
    reset_n <= 1'b0;
    settle(2);
    `CHK(switch_closed, 1'b0)
    reset_n <= 1'b1;
    reg_read(swo_pkg::ADDR_CTRL, rd);
    `CHK(rd, 32'h0)
    settle(2);
    `CHK(switch_closed, 1'b0)
    results();
  end
endmodule : swo_switch_output_test
